//--- src/rcc_top.sv
// rcc_top: reset-cause status and control register with master reset combine
// assumes rst_n is the power-on reset and that every source input is
// synchronous to clk; software reaches the registers over a plain port
//
// What this block does
// - brown-out event sets the brown-out flag at bit 1.
// - power-up also leaves the brown-out flag set.
// - power-up sets the power-on flag at bit 0.
// - software may set or clear every cause flag, but an active source keeps its flag set.
// - writing a flag only stores it; it never pulls the system reset.
// - any active reset source asserts the master system reset.
// - each reset kind sets its own cause flag.
// - power-on clears all cause flags except power-on and brown-out, which set.
// - low external reset pin sets the pin-reset flag at bit 7.
`timescale 1ns/1ps
module rcc_top
  import rcc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  output logic                   irq,
  input  wire logic              brownOutDet,
  input  wire logic              externalResetPinN,
  input  wire logic              softResetReq,
  input  wire logic              watchdogExpired,
  input  wire logic              trapConflict,
  input  wire logic              badOpcodeOrWreg,
  input  wire logic              wakeFromSleep,
  input  wire logic              wakeFromIdle,
  input  wire logic              bandgapStable,
  output logic                   masterSystemReset,
  output logic                   softWatchdogEnable,
  output logic                   lowVoltDetectEnable,
  output logic      [LVLM_W-1:0] lowVoltDetectLimit
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  rcc_evt_if evt ();

  logic [DATA_W-1:0] srcRaw;
  logic [DATA_W-1:0] causeQ;
  logic [DATA_W-1:0] causeD;
  logic [DATA_W-1:0] rdDataQ;
  logic [DATA_W-1:0] rdDataD;
  logic              sysRstQ;
  logic              sysRstD;
  logic [DATA_W-1:0] irqStatus;
  logic [DATA_W-1:0] irqMask;
  logic              selCause;
  logic              selStat;
  logic              selMask;
  logic              wrCause;
  logic              clrStat;
  logic              wrMask;

  // ----------------------------------------------------------------
  // source vector in register layout
  // ----------------------------------------------------------------
  // the pin is active low; all other sources are active high
  always_comb begin
    srcRaw              = '0;
    srcRaw[BIT_BROWN]   = brownOutDet;
    srcRaw[BIT_IDLE]    = wakeFromIdle;
    srcRaw[BIT_SLEEP]   = wakeFromSleep;
    srcRaw[BIT_WDOG]    = watchdogExpired;
    srcRaw[BIT_SOFT]    = softResetReq;
    srcRaw[BIT_PIN]     = ~externalResetPinN;
    srcRaw[BIT_BADOP]   = badOpcodeOrWreg;
    srcRaw[BIT_TRAP]    = trapConflict;
  end

  rcc_event_detect uDetect (
    .clk    (clk),
    .rst_n  (rst_n),
    .clkEn  (clkEn),
    .srcRaw (srcRaw),
    .evt    (evt)
  );

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  assign selCause = (regAddr == OFF_CAUSE);
  assign selStat  = (regAddr == OFF_IRQ_STAT);
  assign selMask  = (regAddr == OFF_IRQ_MASK);
  assign wrCause  = regWr & selCause;
  assign clrStat  = regWr & selStat;
  assign wrMask   = regWr & selMask;

  // ----------------------------------------------------------------
  // cause register next value
  // ----------------------------------------------------------------
  // software write first, hardware sets after, so an event arriving in
  // the cycle of a clearing write is still recorded
  always_comb begin
    causeD = causeQ;
    if (wrCause) begin
      causeD = (causeQ & ~CAUSE_WR_MASK) | (regWrData & CAUSE_WR_MASK);
    end
    causeD = causeD | (evt.level & RESET_SRC_MASK);
    if (evt.level[BIT_BROWN]) begin
      causeD[BIT_BROWN] = 1'b1;
    end
    if (evt.level[BIT_PIN]) begin
      causeD[BIT_PIN] = 1'b1;
    end
    if (evt.level[BIT_TRAP]) begin
      causeD[BIT_TRAP] = 1'b1;
    end
    if (evt.level[BIT_BADOP]) begin
      causeD[BIT_BADOP] = 1'b1;
    end
    if (evt.level[BIT_SOFT]) begin
      causeD[BIT_SOFT] = 1'b1;
    end
    if (evt.level[BIT_WDOG]) begin
      causeD[BIT_WDOG] = 1'b1;
    end
    if (evt.level[BIT_SLEEP]) begin
      causeD[BIT_SLEEP] = 1'b1;
    end
    if (evt.level[BIT_IDLE]) begin
      causeD[BIT_IDLE] = 1'b1;
    end
    // band-gap status is read-only and follows the analog flag
    causeD[BIT_BANDGAP] = bandgapStable;
  end

  // ----------------------------------------------------------------
  // master reset next value
  // ----------------------------------------------------------------
  // built from sources only: no path from the register port reaches it,
  // so setting a flag in software can never start a reset
  always_comb begin
    sysRstD = |(evt.level & RESET_SRC_MASK);
    if (wrCause) begin
      sysRstD = |(evt.level & RESET_SRC_MASK);
    end
  end

  // ----------------------------------------------------------------
  // read data next value
  // ----------------------------------------------------------------
  // data stand only in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdDataD = '0;
    if (regRd) begin
      if (selCause) begin
        rdDataD = causeQ;
      end else if (selStat) begin
        rdDataD = irqStatus;
      end else if (selMask) begin
        rdDataD = irqMask;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // the cause register is only touched by the power-on reset; the master
  // reset it drives must not clear the flags that explain it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      causeQ  <= CAUSE_RESET;
      sysRstQ <= 1'b1;
      rdDataQ <= '0;
    end else if (clkEn) begin
      causeQ  <= causeD;
      sysRstQ <= sysRstD;
      rdDataQ <= rdDataD;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  rcc_irq_ctrl uIrq (
    .clk     (clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .evt     (evt),
    .statClr (clrStat),
    .maskWr  (wrMask),
    .wrData  (regWrData),
    .status  (irqStatus),
    .mask    (irqMask),
    .irq     (irq)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData           = rdDataQ;
  assign masterSystemReset   = sysRstQ;
  assign softWatchdogEnable  = causeQ[BIT_WDOG_EN];
  assign lowVoltDetectEnable = causeQ[BIT_LV_EN];
  assign lowVoltDetectLimit  = causeQ[LVLM_LSB +: LVLM_W];

endmodule : rcc_top

//--- src/rcc_pkg.sv
// rcc_pkg: constants shared by the reset-cause block and its helpers
// assumes a 16-bit register port with a 4-bit word index
package rcc_pkg;

  // ----------------------------------------------------------------
  // bus shape and register offsets
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;

  localparam logic [ADDR_W-1:0] OFF_CAUSE    = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h2;

  // ----------------------------------------------------------------
  // reset_cause_control field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_POR     = 0;
  localparam int unsigned BIT_BROWN   = 1;
  localparam int unsigned BIT_IDLE    = 2;
  localparam int unsigned BIT_SLEEP   = 3;
  localparam int unsigned BIT_WDOG    = 4;
  localparam int unsigned BIT_WDOG_EN = 5;
  localparam int unsigned BIT_SOFT    = 6;
  localparam int unsigned BIT_PIN     = 7;
  localparam int unsigned LVLM_LSB    = 8;
  localparam int unsigned LVLM_W      = 4;
  localparam int unsigned BIT_LV_EN   = 12;
  localparam int unsigned BIT_BANDGAP = 13;
  localparam int unsigned BIT_BADOP   = 14;
  localparam int unsigned BIT_TRAP    = 15;

  // ----------------------------------------------------------------
  // reset values and field masks
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_POR_FLAG   = 16'h0001;
  localparam logic [DATA_W-1:0] RST_BROWN_FLAG = 16'h0002;
  localparam logic [DATA_W-1:0] RST_LVLM       = 16'h0500;
  localparam logic [DATA_W-1:0] CAUSE_RESET    = RST_POR_FLAG | RST_BROWN_FLAG | RST_LVLM;

  // flags set by hardware events
  localparam logic [DATA_W-1:0] CAUSE_FLAG_MASK = 16'hC0DF;
  // events that also pull the master reset
  localparam logic [DATA_W-1:0] RESET_SRC_MASK  = 16'hC0D2;
  // everything but the band-gap status is writable
  localparam logic [DATA_W-1:0] CAUSE_WR_MASK   = 16'hDFFF;
  localparam logic [DATA_W-1:0] IRQ_RESET       = 16'h0000;

endpackage : rcc_pkg

//--- src/rcc_evt_if.sv
// rcc_evt_if: registered event levels and their rising-edge pulses
// assumes producer and consumers share one clock
`timescale 1ns/1ps
interface rcc_evt_if;
  import rcc_pkg::*;
  logic [DATA_W-1:0] level;
  logic [DATA_W-1:0] rise;
  modport src (output level, output rise);
  modport snk (input level, input rise);
endinterface : rcc_evt_if

//--- src/rcc_event_detect.sv
// rcc_event_detect: registers reset and wake sources, finds their rising edges
// assumes source inputs are synchronous to clk
`timescale 1ns/1ps
module rcc_event_detect
  import rcc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic [DATA_W-1:0] srcRaw,
  rcc_evt_if.src                 evt
);

  logic [DATA_W-1:0] levelQ;
  logic [DATA_W-1:0] levelD;
  logic [DATA_W-1:0] prevQ;
  logic [DATA_W-1:0] prevD;

  // ----------------------------------------------------------------
  // per-bit sampling and edge detection
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : gBit
      always_comb begin
        levelD[i] = clkEn ? srcRaw[i] : levelQ[i];
        prevD[i]  = clkEn ? levelQ[i] : prevQ[i];
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          levelQ[i] <= 1'b0;
          prevQ[i]  <= 1'b0;
        end else begin
          levelQ[i] <= levelD[i];
          prevQ[i]  <= prevD[i];
        end
      end
      assign evt.rise[i] = levelQ[i] & ~prevQ[i];
    end
  endgenerate

  assign evt.level = levelQ;

endmodule : rcc_event_detect

//--- src/rcc_irq_ctrl.sv
// rcc_irq_ctrl: sticky event status, write-one-to-clear, mask, level interrupt
// assumes one-cycle write strobes already decoded per register
`timescale 1ns/1ps
module rcc_irq_ctrl
  import rcc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  rcc_evt_if.snk                 evt,
  input  wire logic              statClr,
  input  wire logic              maskWr,
  input  wire logic [DATA_W-1:0] wrData,
  output logic      [DATA_W-1:0] status,
  output logic      [DATA_W-1:0] mask,
  output logic                   irq
);

  logic [DATA_W-1:0] statQ;
  logic [DATA_W-1:0] statD;
  logic [DATA_W-1:0] maskQ;
  logic [DATA_W-1:0] maskD;
  logic              irqQ;
  logic              irqD;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    statD = statQ;
    maskD = maskQ;
    if (statClr) begin
      statD = statD & ~wrData;
    end
    // a new event beats a clear in the same cycle
    statD = statD | (evt.rise & CAUSE_FLAG_MASK);
    if (maskWr) begin
      maskD = wrData & CAUSE_FLAG_MASK;
    end
    irqD = |(statD & maskD);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statQ <= IRQ_RESET;
      maskQ <= IRQ_RESET;
      irqQ  <= 1'b0;
    end else if (clkEn) begin
      statQ <= statD;
      maskQ <= maskD;
      irqQ  <= irqD;
    end
  end

  assign status = statQ;
  assign mask   = maskQ;
  assign irq    = irqQ;

endmodule : rcc_irq_ctrl

//--- test/rcc_top_chk.sv
// rcc_top_chk: port-level assertions for the reset-cause block
// assumes it is bound into rcc_top and sees only that module's ports
`timescale 1ns/1ps
module rcc_top_chk
  import rcc_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              clkEn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic              irq,
  input wire logic              brownOutDet,
  input wire logic              externalResetPinN,
  input wire logic              softResetReq,
  input wire logic              watchdogExpired,
  input wire logic              trapConflict,
  input wire logic              badOpcodeOrWreg,
  input wire logic              masterSystemReset
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // wake events are left out: they set flags but never reset
  logic srcAny;
  assign srcAny = brownOutDet | ~externalResetPinN | softResetReq | watchdogExpired
                | trapConflict | badOpcodeOrWreg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !clkEn);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // sources pass a sampling flop and the reset flop: seen two edges later
  a_src_sets_rst: assert property (srcAny |-> ##2 masterSystemReset)
    else $error("reset source did not raise master reset");
  a_pin_low_rst: assert property (!externalResetPinN |-> ##2 masterSystemReset)
    else $error("low reset pin did not raise master reset");
  a_quiet_no_rst: assert property (!srcAny |-> ##2 !masterSystemReset)
    else $error("master reset high with no source");
  a_wr_no_rst: assert property (regWr && !srcAny |-> ##2 !masterSystemReset)
    else $error("register write raised master reset");
  a_rst_holds: assert property (srcAny [*3] |-> masterSystemReset)
    else $error("master reset dropped while source held");
  a_rst_rise_cause: assert property ($rose(masterSystemReset) |-> $past(srcAny, 2))
    else $error("master reset rose without a source");
  a_rst_fall_cause: assert property ($fell(masterSystemReset) |-> !$past(srcAny, 2))
    else $error("master reset fell with a source active");
  a_rd_idle_zero: assert property (!regRd |=> regRdData == '0)
    else $error("read data not zero outside read answer");
  a_rd_unmapped_zero: assert property (regRd && regAddr > OFF_IRQ_MASK |=> regRdData == '0)
    else $error("unmapped read returned nonzero");
  c_rst_rise: cover property ($rose(masterSystemReset));
  c_rd_data: cover property (regRd ##1 regRdData != '0);
  c_irq_rise: cover property ($rose(irq));
endmodule : rcc_top_chk

bind rcc_top rcc_top_chk u_chk (.clk, .rst_n, .clkEn, .regAddr, .regWr, .regRd, .regRdData,
  .irq, .brownOutDet, .externalResetPinN, .softResetReq, .watchdogExpired, .trapConflict,
  .badOpcodeOrWreg, .masterSystemReset);

//--- test/rcc_top_test.sv
// rcc_top_test: register-port testbench for the reset-cause block
// assumes rcc_top and rcc_top_chk are compiled alongside; clkEn held high
`timescale 1ns/1ps
module rcc_top_test
  import rcc_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic              irq;
  logic              masterSystemReset;
  logic              softWatchdogEnable;
  logic              lowVoltDetectEnable;
  logic [LVLM_W-1:0] lowVoltDetectLimit;
  logic [7:0]        ev = '0;
  logic              bandgapStable = 1'b1;
  logic [DATA_W-1:0] got;
  int                errCount = 0;
  int                compares = 0;
  int                cycles = 0;
  // event index to flag bit: brown, pin, soft, wdt, trap, bad, sleep, idle
  int                pos [8] = '{BIT_BROWN, BIT_PIN, BIT_SOFT, BIT_WDOG, BIT_TRAP, BIT_BADOP,
                                 BIT_SLEEP, BIT_IDLE};

  always #5 clk = ~clk;

  rcc_top DUT (.clk, .rst_n, .clkEn(1'b1), .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .irq, .brownOutDet(ev[0]), .externalResetPinN(~ev[1]), .softResetReq(ev[2]),
    .watchdogExpired(ev[3]), .trapConflict(ev[4]), .badOpcodeOrWreg(ev[5]),
    .wakeFromSleep(ev[6]), .wakeFromIdle(ev[7]), .bandgapStable, .masterSystemReset,
    .softWatchdogEnable, .lowVoltDetectEnable, .lowVoltDetectLimit);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic testDone;
    $display("compares %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : testDone

  task automatic chk(string n, logic [DATA_W-1:0] e, logic [DATA_W-1:0] a);
    compares++;
    if (a !== e) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", n, e, a);
    end
  endtask : chk

  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rc(string n, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 got = regRdData;
    chk(n, e, got);
  endtask : rc

  task automatic fire(int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("mrst on", {15'h0, i < 6}, {15'h0, masterSystemReset});
    @(posedge clk);
    ev[i] <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("mrst off", 16'h0000, {15'h0, masterSystemReset});
  endtask : fire

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errCount++;
      testDone;
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rc("cause reset", OFF_CAUSE, 16'h2503);
    chk("limit reset", 16'h0005, {12'h0, lowVoltDetectLimit});
    rc("stat reset", OFF_IRQ_STAT, 16'h0000);
    wr(OFF_CAUSE, 16'hDFFF);
    // look past the edge that took the write, once the reset flop has settled
    #1 chk("write no rst", 16'h0000, {15'h0, masterSystemReset});
    rc("cause all", OFF_CAUSE, 16'hFFFF);
    chk("ctl outs", 16'h003F, {10'h0, softWatchdogEnable, lowVoltDetectEnable,
      lowVoltDetectLimit});
    wr(OFF_CAUSE, 16'h0000);
    rc("cause clear", OFF_CAUSE, 16'h2000);
    wr(OFF_IRQ_MASK, 16'hFFFF);
    rc("mask bits", OFF_IRQ_MASK, 16'hC0DF);
    wr(OFF_IRQ_MASK, 16'h0000);
    wr(4'h3, 16'hFFFF);
    rc("unmapped", 4'h3, 16'h0000);
    rc("cause kept", OFF_CAUSE, 16'h2000);
    for (int i = 0; i < 8; i++) begin
      fire(i);
      rc("cause flag", OFF_CAUSE, 16'h2000 | (16'h0001 << pos[i]));
      rc("irq stat", OFF_IRQ_STAT, 16'h0001 << pos[i]);
      chk("irq masked", 16'h0000, {15'h0, irq});
      wr(OFF_IRQ_STAT, 16'h0001 << pos[i]);
      wr(OFF_CAUSE, 16'h0000);
    end
    wr(OFF_IRQ_MASK, 16'h0002);
    fire(0);
    chk("irq set", 16'h0001, {15'h0, irq});
    wr(OFF_IRQ_STAT, 16'h0002);
    repeat (2) @(posedge clk);
    #1 chk("irq clear", 16'h0000, {15'h0, irq});
    // second power-on in mid-run: every flag written set must fall back
    wr(OFF_CAUSE, 16'hDFFF);
    wr(OFF_IRQ_MASK, 16'hFFFF);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rc("cause rerun", OFF_CAUSE, 16'h2503);
    rc("mask rerun", OFF_IRQ_MASK, 16'h0000);
    testDone;
  end
endmodule : rcc_top_test
